// ---- pkg/dram_ctl_defs.svh ----
`ifndef DRAM_CTL_DEFS_SVH
`define DRAM_CTL_DEFS_SVH

`define CLK_PERIOD_NS 8
`define ROW_BITS 10
`define COL_BITS 10
`define DATA_BITS 4
`define ROW_COUNT 1024
`define REFRESH_PERIOD_NS 16000000
`define REFRESH_INTERVAL_CYC ((`REFRESH_PERIOD_NS / `ROW_COUNT) / `CLK_PERIOD_NS)
`define POWERUP_PAUSE_NS 100000
`define POWERUP_PAUSE_CYC ((`POWERUP_PAUSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CYCLES 8
`define PAGE_ROW_LOW_MAX_NS 100000
`define PAGE_ROW_LOW_MAX_CYC (`PAGE_ROW_LOW_MAX_NS / `CLK_PERIOD_NS)
`define ROW_LOW_MAX_NS 10000
`define ROW_LOW_MAX_CYC (`ROW_LOW_MAX_NS / `CLK_PERIOD_NS)
`define ROW_SETUP_NS 20
`define ROW_SETUP_CYC ((`ROW_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_LOW_NS 40
`define COL_LOW_CYC ((`COL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_CYCLE_TIME_NS 40
`define PAGE_CYCLE_TIME_CYC ((`PAGE_CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COLUMN_PRECHARGE_TIME_NS 10
`define COLUMN_PRECHARGE_TIME_CYC ((`COLUMN_PRECHARGE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_PRECHARGE_NS 90
`define ROW_PRECHARGE_CYC ((`ROW_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_LOW_MIN_NS 120
`define ROW_LOW_MIN_CYC ((`ROW_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_STEP_NS 25
`define WE_STEP_CYC ((`WE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pkg/dram_ctl_pkg.sv ----
package dram_ctl_pkg;
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_WAKE = 4'h1,
    ST_IDLE = 4'h2,
    ST_ROW = 4'h3,
    ST_COL = 4'h4,
    ST_WE = 4'h5,
    ST_COL_HI = 4'h6,
    ST_PRE = 4'h7,
    ST_CBR_SET = 4'h8,
    ST_CBR_ROW = 4'h9
  } state_e;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW = 2'h2
  } op_e;

  typedef logic [16:0] count_t;
endpackage : dram_ctl_pkg

// ---- design/cycle_timer.sv ----
`timescale 1ns/1ps
module cycle_timer #(
  parameter int WIDTH = 17
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  output logic done_o
);
  logic [WIDTH-1:0] cnt_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= value_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign done_o = (cnt_r == '0);
endmodule : cycle_timer

// ---- design/dram_host_ctl.sv ----
`timescale 1ns/1ps
`include "dram_ctl_defs.svh"
module dram_host_ctl #(
  parameter int REFRESH_INTERVAL = `REFRESH_INTERVAL_CYC,
  parameter int POWERUP_PAUSE = `POWERUP_PAUSE_CYC,
  parameter int PAGE_ROW_LOW_MAX = `PAGE_ROW_LOW_MAX_CYC,
  parameter int ROW_LOW_MAX = `ROW_LOW_MAX_CYC,
  parameter int PAGE_CYCLE_TIME = `PAGE_CYCLE_TIME_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_op_i,
  input wire logic [19:0] req_addr_i,
  input wire logic [3:0] req_wdata_i,
  input wire logic req_page_i,
  output logic req_ready_o,
  output logic rdata_valid_o,
  output logic [3:0] rdata_o,
  output logic init_done_o,
  output logic row_strobe_n_o,
  output logic col_strobe_n_o,
  output logic write_strobe_n_o,
  output logic out_enable_n_o,
  output logic [9:0] mux_address_pins_o,
  input wire logic [3:0] shared_data_pins_i,
  output logic [3:0] shared_data_pins_o,
  output logic [3:0] shared_data_pins_oe_o
);
  typedef struct packed {
    dram_ctl_pkg::state_e st;
    dram_ctl_pkg::op_e op;
    logic [9:0] col;
    logic [3:0] wdata;
    logic [3:0] wake;
    logic page;
    logic [9:0] row;
    logic paused;
    logic refresh_due;
    logic [16:0] refresh_cnt;
    logic [16:0] row_low_cnt;
    logic ready;
    logic rvalid;
    logic [3:0] rdata;
    logic init_done;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [9:0] addr;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
  } state_s;

  state_s cur_r;
  state_s cur_nxt;
  logic [3:0] dq_s1_r;
  logic [3:0] dq_s2_r;
  logic [3:0] dq_s3_r;
  logic tmr_load;
  dram_ctl_pkg::count_t tmr_val;
  logic tmr_done;
  logic row_limit;

  cycle_timer #(.WIDTH(17)) u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );

  always_ff @(posedge mclk_i) begin
    dq_s1_r <= shared_data_pins_i;
    dq_s2_r <= dq_s1_r;
    dq_s3_r <= dq_s2_r;
  end

  assign row_limit = cur_r.page ? (cur_r.row_low_cnt >= 17'(PAGE_ROW_LOW_MAX - 16))
                                : (cur_r.row_low_cnt >= 17'(ROW_LOW_MAX - 16));

  always_comb begin
    cur_nxt = cur_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    cur_nxt.rvalid = 1'b0;
    cur_nxt.ready = 1'b0;
    if (cur_r.refresh_cnt == '0) begin
      cur_nxt.refresh_cnt = 17'(REFRESH_INTERVAL - 1);
    end else begin
      cur_nxt.refresh_cnt = cur_r.refresh_cnt - 17'h00001;
    end
    cur_nxt.row_low_cnt = cur_r.ras_n ? 17'h00000 : cur_r.row_low_cnt + 17'h00001;
    case (cur_r.st)
      dram_ctl_pkg::ST_POWERUP: begin
        if (!cur_r.paused) begin
          cur_nxt.paused = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 17'(POWERUP_PAUSE);
        end else if (tmr_done) begin
          cur_nxt.st = dram_ctl_pkg::ST_WAKE;
        end
      end
      dram_ctl_pkg::ST_WAKE: begin
        if (cur_r.wake == 4'(`WAKE_CYCLES)) begin
          cur_nxt.init_done = 1'b1;
          cur_nxt.st = dram_ctl_pkg::ST_IDLE;
        end else begin
          cur_nxt.wake = cur_r.wake + 4'h1;
          cur_nxt.cas_n = 1'b0;
          cur_nxt.we_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 17'(`COLUMN_PRECHARGE_TIME_CYC);
          cur_nxt.st = dram_ctl_pkg::ST_CBR_SET;
        end
      end
      dram_ctl_pkg::ST_IDLE: begin
        // a request already offered ready is taken before a pending refresh
        if (req_valid_i && cur_r.ready) begin
          cur_nxt.op = dram_ctl_pkg::op_e'(req_op_i);
          cur_nxt.col = req_addr_i[9:0];
          cur_nxt.wdata = req_wdata_i;
          cur_nxt.page = req_page_i;
          cur_nxt.row = req_addr_i[19:10];
          cur_nxt.addr = req_addr_i[19:10];
          cur_nxt.ras_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = 17'(`ROW_SETUP_CYC);
          cur_nxt.st = dram_ctl_pkg::ST_ROW;
        end else if (cur_r.refresh_due) begin
          cur_nxt.refresh_due = 1'b0;
          cur_nxt.cas_n = 1'b0;
          cur_nxt.we_n = 1'b1;
          cur_nxt.oe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 17'(`COLUMN_PRECHARGE_TIME_CYC);
          cur_nxt.st = dram_ctl_pkg::ST_CBR_SET;
        end else begin
          cur_nxt.ready = 1'b1;
        end
      end
      dram_ctl_pkg::ST_ROW: begin
        if (tmr_done) begin
          cur_nxt.addr = cur_r.col;
          if (cur_r.op == dram_ctl_pkg::OP_WRITE) begin
            cur_nxt.we_n = 1'b0;
            cur_nxt.oe_n = 1'b1;
            cur_nxt.dq_o = cur_r.wdata;
            cur_nxt.dq_oe = 4'hF;
          end else begin
            cur_nxt.we_n = 1'b1;
            cur_nxt.oe_n = 1'b0;
            cur_nxt.dq_oe = 4'h0;
          end
          cur_nxt.cas_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = 17'(PAGE_CYCLE_TIME - `COLUMN_PRECHARGE_TIME_CYC);
          cur_nxt.st = dram_ctl_pkg::ST_COL;
        end
      end
      dram_ctl_pkg::ST_COL: begin
        if (tmr_done) begin
          if (cur_r.op == dram_ctl_pkg::OP_WRITE) begin
            cur_nxt.cas_n = 1'b1;
            cur_nxt.st = dram_ctl_pkg::ST_COL_HI;
          end else begin
            cur_nxt.rdata = dq_s3_r;
            cur_nxt.rvalid = 1'b1;
            if (cur_r.op == dram_ctl_pkg::OP_RMW) begin
              cur_nxt.oe_n = 1'b1;
              tmr_load = 1'b1;
              tmr_val = 17'(`WE_STEP_CYC);
              cur_nxt.st = dram_ctl_pkg::ST_WE;
            end else begin
              cur_nxt.cas_n = 1'b1;
              cur_nxt.st = dram_ctl_pkg::ST_COL_HI;
            end
          end
          tmr_load = tmr_load | (cur_nxt.st == dram_ctl_pkg::ST_COL_HI);
          if (cur_nxt.st == dram_ctl_pkg::ST_COL_HI) begin
            tmr_val = 17'(`COLUMN_PRECHARGE_TIME_CYC);
          end
        end
      end
      dram_ctl_pkg::ST_WE: begin
        if (tmr_done && cur_r.we_n) begin
          cur_nxt.we_n = 1'b0;
          cur_nxt.dq_o = cur_r.wdata;
          cur_nxt.dq_oe = 4'hF;
          tmr_load = 1'b1;
          tmr_val = 17'(`WE_STEP_CYC);
        end else if (tmr_done) begin
          cur_nxt.cas_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 17'(`COLUMN_PRECHARGE_TIME_CYC);
          cur_nxt.st = dram_ctl_pkg::ST_COL_HI;
        end
      end
      dram_ctl_pkg::ST_COL_HI: begin
        cur_nxt.dq_oe = 4'h0;
        cur_nxt.we_n = 1'b1;
        cur_nxt.oe_n = 1'b1;
        if (tmr_done) begin
          if (cur_r.ready && req_valid_i) begin
            cur_nxt.op = dram_ctl_pkg::op_e'(req_op_i);
            cur_nxt.col = req_addr_i[9:0];
            cur_nxt.wdata = req_wdata_i;
            cur_nxt.page = req_page_i;
            tmr_load = 1'b1;
            tmr_val = 17'h00000;
            cur_nxt.st = dram_ctl_pkg::ST_ROW;
          end else if (!cur_r.ready && cur_r.page && !row_limit && !cur_r.refresh_due
                       && req_valid_i && req_addr_i[19:10] == cur_r.row) begin
            // offer one page access, only for a request in the open row
            cur_nxt.ready = 1'b1;
          end else begin
            cur_nxt.ras_n = 1'b1;
            tmr_load = 1'b1;
            tmr_val = 17'(`ROW_PRECHARGE_CYC);
            cur_nxt.st = dram_ctl_pkg::ST_PRE;
          end
        end
      end
      dram_ctl_pkg::ST_PRE: begin
        cur_nxt.cas_n = 1'b1;
        if (tmr_done) begin
          cur_nxt.st = cur_r.init_done ? dram_ctl_pkg::ST_IDLE : dram_ctl_pkg::ST_WAKE;
        end
      end
      dram_ctl_pkg::ST_CBR_SET: begin
        if (tmr_done) begin
          cur_nxt.ras_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = 17'(`ROW_LOW_MIN_CYC);
          cur_nxt.st = dram_ctl_pkg::ST_CBR_ROW;
        end
      end
      dram_ctl_pkg::ST_CBR_ROW: begin
        if (tmr_done) begin
          cur_nxt.ras_n = 1'b1;
          cur_nxt.cas_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 17'(`ROW_PRECHARGE_CYC);
          cur_nxt.page = 1'b0;
          cur_nxt.st = dram_ctl_pkg::ST_PRE;
        end
      end
      default: begin
        cur_nxt.st = dram_ctl_pkg::ST_IDLE;
      end
    endcase
    // set after the state logic so a new refresh tick beats a same-cycle clear
    if (cur_r.refresh_cnt == '0 && cur_r.st != dram_ctl_pkg::ST_POWERUP) begin
      cur_nxt.refresh_due = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cur_r <= '0;
      cur_r.st <= dram_ctl_pkg::ST_POWERUP;
      cur_r.refresh_cnt <= 17'(REFRESH_INTERVAL - 1);
      cur_r.ras_n <= 1'b1;
      cur_r.cas_n <= 1'b1;
      cur_r.we_n <= 1'b1;
      cur_r.oe_n <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      init_done_o <= 1'b0;
    end else begin
      init_done_o <= cur_nxt.init_done;
    end
  end

  assign req_ready_o = cur_r.ready;
  assign rdata_valid_o = cur_r.rvalid;
  assign rdata_o = cur_r.rdata;
  assign row_strobe_n_o = cur_r.ras_n;
  assign col_strobe_n_o = cur_r.cas_n;
  assign write_strobe_n_o = cur_r.we_n;
  assign out_enable_n_o = cur_r.oe_n;
  assign mux_address_pins_o = cur_r.addr;
  assign shared_data_pins_o = cur_r.dq_o;
  assign shared_data_pins_oe_o = cur_r.dq_oe;
endmodule : dram_host_ctl

// ---- bench/dram_host_ctl_chk.sv ----
`timescale 1ns/1ps
module dram_host_ctl_chk #(
  parameter int REFRESH_INTERVAL = 200,
  parameter int PAGE_ROW_LOW_MAX = 60,
  parameter int PAGE_CYCLE_TIME = 5
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_ready_o,
  input wire logic init_done_o,
  input wire logic row_strobe_n_o,
  input wire logic col_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic out_enable_n_o,
  input wire logic [3:0] shared_data_pins_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [16:0] row_cnt_r, gap_r, ref_r;
  // row low time, spacing of column falls, time since last refresh
  always_ff @(posedge mclk_i) begin
    if (rst_i || row_strobe_n_o) row_cnt_r <= 17'h0;
    else row_cnt_r <= row_cnt_r + 17'h1;
    if (rst_i || row_strobe_n_o) gap_r <= 17'h1FFFF;
    else if ($fell(col_strobe_n_o)) gap_r <= 17'h1;
    else if (gap_r != 17'h1FFFF) gap_r <= gap_r + 17'h1;
    if (rst_i || !init_done_o || ($fell(row_strobe_n_o) && !col_strobe_n_o)) ref_r <= 17'h0;
    else ref_r <= ref_r + 17'h1;
  end
  AST_CBR_WE_HIGH: assert property ($fell(row_strobe_n_o) && !col_strobe_n_o |-> write_strobe_n_o)
    else $error("refresh with write strobe low");
  AST_ROW_LOW_LIMIT: assert property (row_cnt_r <= PAGE_ROW_LOW_MAX)
    else $error("row strobe low too long");
  AST_PAGE_SPACING: assert property (
    $fell(col_strobe_n_o) && !row_strobe_n_o |-> gap_r >= PAGE_CYCLE_TIME)
    else $error("column accesses too close");
  AST_REFRESH_GAP: assert property (ref_r <= REFRESH_INTERVAL + PAGE_ROW_LOW_MAX + 64)
    else $error("refresh overdue");
  AST_NO_CLASH: assert property (!out_enable_n_o |-> shared_data_pins_oe_o == 4'h0)
    else $error("driving pins with output enable low");
  AST_WDATA_DRIVEN: assert property (
    (($fell(col_strobe_n_o) && !write_strobe_n_o) || ($fell(write_strobe_n_o) && !col_strobe_n_o))
    && !row_strobe_n_o |-> shared_data_pins_oe_o == 4'hF)
    else $error("write data not driven at latch edge");
  AST_LATE_WE_OE: assert property ($fell(write_strobe_n_o) && !col_strobe_n_o |-> out_enable_n_o)
    else $error("late write with output enable low");
  AST_READ_WE: assert property (
    $fell(col_strobe_n_o) && !row_strobe_n_o && !out_enable_n_o |-> write_strobe_n_o)
    else $error("read column access with write strobe low");
  AST_COL_PRECHARGE: assert property ($rose(col_strobe_n_o) |-> col_strobe_n_o [*2])
    else $error("column precharge too short");
  AST_ROW_PRECHARGE: assert property ($rose(row_strobe_n_o) |-> row_strobe_n_o [*8])
    else $error("row precharge too short");
  AST_READY_AFTER_INIT: assert property (req_ready_o |-> init_done_o)
    else $error("ready before wake-up done");
endmodule : dram_host_ctl_chk

bind dram_host_ctl dram_host_ctl_chk #(.REFRESH_INTERVAL(REFRESH_INTERVAL),
  .PAGE_ROW_LOW_MAX(PAGE_ROW_LOW_MAX), .PAGE_CYCLE_TIME(PAGE_CYCLE_TIME)) u_chk (
  .mclk_i, .rst_i, .req_ready_o, .init_done_o, .row_strobe_n_o, .col_strobe_n_o,
  .write_strobe_n_o, .out_enable_n_o, .shared_data_pins_oe_o);

// ---- bench/dram_dev_model.sv ----
`timescale 1ns/1ps
module dram_dev_model (
  input wire logic row_n_i,
  input wire logic col_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic dq_oe_o,
  output logic [15:0] cbr_cnt_o,
  output logic [15:0] test_cnt_o
);
  logic [3:0] mem [logic [19:0]];
  logic [9:0] row_q, col_q, ref_row_q;
  logic acc_q, early_q, test_q;
  initial begin
    cbr_cnt_o = 16'h0;
    test_cnt_o = 16'h0;
    ref_row_q = 10'h0;
    acc_q = 1'b0;
    early_q = 1'b0;
    test_q = 1'b1;
    dq_o = 4'h0;
  end
  // pins are looked at 1 ns after a strobe edge so address and strobe have both settled
  always @(negedge row_n_i) begin
    #1;
    if (!col_n_i && we_n_i) begin
      cbr_cnt_o <= cbr_cnt_o + 16'h1;
      ref_row_q <= ref_row_q + 10'h1;
      test_q <= 1'b0;
    end else if (!col_n_i) begin
      test_cnt_o <= test_cnt_o + 16'h1;
      test_q <= 1'b1;
    end else row_q <= addr_i;
  end
  always @(negedge col_n_i) begin
    #1;
    if (!row_n_i) begin
      col_q = addr_i;
      early_q = !we_n_i;
      acc_q = 1'b1;
      dq_o = mem.exists({row_q, addr_i}) ? mem[{row_q, addr_i}] : 4'h0;
      #1;
      if (early_q) mem[{row_q, col_q}] = dq_i;
    end
  end
  always @(negedge we_n_i) begin
    #1;
    if (!row_n_i && !col_n_i) mem[{row_q, col_q}] = dq_i;
  end
  always @(posedge col_n_i) acc_q = 1'b0;
  // pins driven only for a non-early-write column access
  assign dq_oe_o = acc_q && !early_q && !oe_n_i;
endmodule : dram_dev_model

// ---- bench/fast_page_dram_access_refresh_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
module fast_page_dram_access_refresh_tb_top;
  localparam int REF_INT = 200;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic [1:0] req_op_i = 2'h0;
  logic [19:0] req_addr_i = 20'h0;
  logic [3:0] req_wdata_i = 4'h0;
  logic req_page_i = 1'b0;
  logic float_q = 1'b0;
  logic req_ready_o, rdata_valid_o, init_done_o, dev_oe;
  logic row_strobe_n_o, col_strobe_n_o, write_strobe_n_o, out_enable_n_o;
  logic [3:0] rdata_o, shared_data_pins_o, shared_data_pins_oe_o, shared_data_pins_i, dev_dq;
  logic [9:0] mux_address_pins_o;
  logic [15:0] cbr_cnt, test_cnt;
  int err_total = 0;
  int compares = 0;
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  // released pins toggle every cycle so a stale value is never read back
  always @(posedge mclk_i) float_q <= ~float_q;
  assign shared_data_pins_i = (|shared_data_pins_oe_o) ? shared_data_pins_o :
    (dev_oe ? dev_dq : {float_q, ~float_q, float_q, ~float_q});
  dram_host_ctl #(.REFRESH_INTERVAL(REF_INT), .POWERUP_PAUSE(4), .PAGE_ROW_LOW_MAX(60),
    .ROW_LOW_MAX(40), .PAGE_CYCLE_TIME(5)) u_dram_host_ctl (
    .mclk_i, .rst_i, .req_valid_i, .req_op_i, .req_addr_i, .req_wdata_i, .req_page_i,
    .req_ready_o, .rdata_valid_o, .rdata_o, .init_done_o, .row_strobe_n_o, .col_strobe_n_o,
    .write_strobe_n_o, .out_enable_n_o, .mux_address_pins_o, .shared_data_pins_i,
    .shared_data_pins_o, .shared_data_pins_oe_o);
  dram_dev_model u_dram_dev_model (.row_n_i(row_strobe_n_o), .col_n_i(col_strobe_n_o),
    .we_n_i(write_strobe_n_o), .oe_n_i(out_enable_n_o), .addr_i(mux_address_pins_o),
    .dq_i(shared_data_pins_i), .dq_o(dev_dq), .dq_oe_o(dev_oe), .cbr_cnt_o(cbr_cnt),
    .test_cnt_o(test_cnt));
  task automatic final_report();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic give_up();
    err_total++;
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
    final_report();
  endtask : give_up
  task automatic do_req(input logic [1:0] op, input logic [19:0] a, input logic [3:0] d,
                        input logic pg, output logic [3:0] q);
    int n;
    n = 0;
    q = 4'h0;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_op_i <= op;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_page_i <= pg;
    #1;
    while (req_ready_o !== 1'b1 && n < 4000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    if (op != dram_ctl_pkg::OP_WRITE) begin
      do begin
        @(posedge mclk_i);
        #1;
        n++;
      end while (rdata_valid_o !== 1'b1 && n < 4100);
      q = rdata_o;
    end
    if (n >= 4000) give_up();
  endtask : do_req
  task automatic t_init();
    int n;
    n = 0;
    while (init_done_o !== 1'b1 && n < 5000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 5000) give_up();
    `CHK(cbr_cnt >= 16'h0008, 1'b1)
    `CHK(test_cnt, 16'h0000)
  endtask : t_init
  task automatic t_rw();
    logic [19:0] a [4] = '{20'hFFC00, 20'h003FF, 20'h556AA, 20'hAA955};
    logic [3:0] d [4] = '{4'hA, 4'h5, 4'h3, 4'hC};
    logic [3:0] q;
    for (int i = 0; i < 4; i++) do_req(dram_ctl_pkg::OP_WRITE, a[i], d[i], 1'b0, q);
    for (int i = 0; i < 4; i++) begin
      do_req(dram_ctl_pkg::OP_READ, a[i], 4'h0, 1'b0, q);
      `CHK(q, d[i])
    end
  endtask : t_rw
  task automatic t_rmw();
    logic [3:0] q;
    do_req(dram_ctl_pkg::OP_RMW, 20'hFFC00, 4'h6, 1'b0, q);
    `CHK(q, 4'hA)
    do_req(dram_ctl_pkg::OP_READ, 20'hFFC00, 4'h0, 1'b0, q);
    `CHK(q, 4'h6)
  endtask : t_rmw
  task automatic t_page();
    logic [3:0] q;
    for (int i = 1; i < 4; i++) do_req(dram_ctl_pkg::OP_WRITE, {10'h0F0, 10'(i)}, 4'(i), i < 3, q);
    for (int i = 1; i < 4; i++) begin
      do_req(dram_ctl_pkg::OP_READ, {10'h0F0, 10'(i)}, 4'h0, i < 3, q);
      `CHK(q, 4'(i))
    end
  endtask : t_page
  task automatic t_refresh();
    logic [15:0] c0;
    logic [3:0] q;
    c0 = cbr_cnt;
    repeat (3 * REF_INT) @(posedge mclk_i);
    #1;
    `CHK((cbr_cnt - c0) >= 16'h0002, 1'b1)
    do_req(dram_ctl_pkg::OP_READ, 20'h556AA, 4'h0, 1'b0, q);
    `CHK(q, 4'h3)
  endtask : t_refresh
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_init();
    t_rw();
    t_rmw();
    t_page();
    t_refresh();
    final_report();
  end
endmodule : fast_page_dram_access_refresh_tb_top
